// ===== rtl/pot_wiper_dev.sv
`timescale 1ns/1ps
// Purpose: wiper device end of the two-wire link, slave only
// Assumes: master supplies SCL; reset stands for power-on and brown-out
// Notes: wiper value is a registered output for the analog side
module pot_wiper_dev (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  pot_if.device bus,
  output logic [6:0] o_wiper,
  output logic o_busy,
  output logic o_collision
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110,
    ST_RSTART = 3'b111
  } dev_state_t;

  // ----------------------------------------------------------------
  // line sampling
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  line_filter #(.INIT(1'b1)) u_scl_filt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_line(bus.scl),
    .o_level(scl_f)
  );
  line_filter #(.INIT(1'b1)) u_sda_filt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_line(bus.sda),
    .o_level(sda_f)
  );

  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;
  assign start_det = scl_f && scl_d && sda_d && !sda_f;
  assign stop_det = scl_f && scl_d && !sda_d && sda_f;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  dev_state_t state;
  dev_state_t next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [6:0] wiper;
  logic [6:0] next_wiper;
  logic sda_drv;
  logic next_sda_drv;
  logic ack_ok;
  logic next_ack_ok;
  logic coll;
  logic next_coll;
  logic in_xfer;
  logic next_in_xfer;

  // address match depends only on the hard-wired constant; general call never matches
  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == pot_pkg::DEV_ADDR) && (a != pot_pkg::GCALL_ADDR);
  endfunction

  function automatic logic [2:0] bit_idx(input logic [3:0] n);
    bit_idx = 3'(pot_pkg::BIT_MSB - int'(n));
  endfunction

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_wiper = wiper;
    next_sda_drv = sda_drv;
    next_ack_ok = ack_ok;
    next_coll = 1'b0;
    next_in_xfer = in_xfer;
    if (start_det) begin
      // any start aborts what is in flight; uncommitted data is dropped
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_sda_drv = 1'b0;
      next_in_xfer = 1'b1;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_sda_drv = 1'b0;
      next_in_xfer = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_drv = 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end
          // drive only after SCL has fallen, so SDA moves while SCL low
          if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            if (state == ST_ADDR) begin
              next_ack_ok = addr_hit(shreg[7:1]);
              next_sda_drv = addr_hit(shreg[7:1]);
              next_state = addr_hit(shreg[7:1]) ? ST_AACK : ST_IDLE;
              next_shreg = {shreg[7:1], shreg[0]};
            end else begin
              next_sda_drv = 1'b1;
              next_state = ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (shreg[0]) begin
              next_state = ST_RDATA;
              next_shreg = {1'b0, wiper};
              next_sda_drv = 1'b1; // leading zero bit of the readback
              next_bitcnt = 4'h1;
            end else begin
              next_state = ST_WDATA;
              next_sda_drv = 1'b0;
              next_bitcnt = 4'h0;
            end
          end
        end
        ST_WACK: begin
          // commit during the acknowledge high phase
          if (scl_rise) begin
            next_wiper = shreg[6:0];
          end
          if (scl_fall) begin
            next_sda_drv = 1'b0;
            next_state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_sda_drv = 1'b0;
              next_state = ST_RACK;
            end else begin
              next_sda_drv = !shreg[bit_idx(bitcnt)];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_ack_ok = !sda_f;
          end
          if (scl_fall) begin
            if (ack_ok) begin
              next_state = ST_RDATA;
              next_shreg = {1'b0, wiper};
              next_sda_drv = 1'b1;
              next_bitcnt = 4'h1;
            end else begin
              // master ended the read; stay off the bus until a new start
              next_state = ST_RSTART;
            end
          end
        end
        ST_RSTART: begin
          // between the last ack and a restart: SCL must not fall before SDA does
          if (scl_rise && !sda_f) begin
            next_coll = 1'b1;
            next_state = ST_IDLE;
          end else if (scl_fall && sda_f) begin
            next_coll = 1'b1;
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      wiper <= pot_pkg::WIPER_RESET;
      sda_drv <= 1'b0;
      ack_ok <= 1'b0;
      coll <= 1'b0;
      in_xfer <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (i_ce) begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      wiper <= next_wiper;
      sda_drv <= next_sda_drv;
      ack_ok <= next_ack_ok;
      coll <= next_coll;
      in_xfer <= next_in_xfer;
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign bus.scl_oe_s = 1'b0;
  assign bus.sda_oe_s = sda_drv;
  assign o_wiper = wiper;
  assign o_busy = in_xfer;
  assign o_collision = coll;
endmodule

// ===== pkg/pot_pkg.sv
// Purpose: shared constants for the wiper two-wire link, both ends
// Assumes: system clock at 20 MHz on both ends
// Notes: bit rate figures only size the master's clock divider
package pot_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h2F;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [6:0] WIPER_RESET = 7'h3F;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int STD_RATE_BPS = 100000;
  localparam int FAST_RATE_BPS = 400000;
  // quarter-bit time in system cycles, rounded up so the rate is never exceeded
  localparam int QTR_STD = (SYS_CLK_HZ + 4 * STD_RATE_BPS - 1) / (4 * STD_RATE_BPS);
  localparam int QTR_FAST = (SYS_CLK_HZ + 4 * FAST_RATE_BPS - 1) / (4 * FAST_RATE_BPS);
  localparam int FILT_LEN = 3;
  localparam int BIT_MSB = 7;
endpackage

// ===== pkg/pot_if.sv
`timescale 1ns/1ps
// Purpose: open-drain two-wire bus joining master and wiper device
// Assumes: pull-ups modelled as wired-and of the enables
// Notes: output enable high pulls the line low
interface pot_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic scl_oe_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = !(scl_oe_m || scl_oe_s);
  assign sda = !(sda_oe_m || sda_oe_s);
  modport master (input scl, input sda, output scl_oe_m, output sda_oe_m);
  modport device (input scl, input sda, output scl_oe_s, output sda_oe_s);
endinterface

// ===== rtl/line_filter.sv
`timescale 1ns/1ps
// Purpose: three-flop sampler and spike filter for one bus line
// Assumes: line is asynchronous to i_sys_clk
// Notes: output changes only once the second and third flops agree
module line_filter #(
  parameter logic INIT = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_line,
  output logic o_level
);
  logic [2:0] sync;
  logic level;
  logic next_level;
  logic [2:0] next_sync;

  always_comb begin
    next_sync = {sync[1:0], i_line};
    next_level = level;
    // first flop feeds only the second; agreement filters single-sample spikes
    if (sync[1] == sync[2]) begin
      next_level = sync[2];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync <= {3{INIT}};
      level <= INIT;
    end else if (i_ce) begin
      sync <= next_sync;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule

// ===== rtl/pot_bus_master.sv
`timescale 1ns/1ps
// Purpose: bus master end that writes or reads the wiper over two wires
// Assumes: single master on the bus
// Notes: one byte per command; stop ends every command
module pot_bus_master #(
  parameter int QTR = pot_pkg::QTR_FAST
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  pot_if.master bus,
  input wire logic i_req,
  input wire logic i_read,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_BITS = 3'b010,
    MS_STOP = 3'b011,
    MS_DONE = 3'b100
  } ms_state_t;

  // ----------------------------------------------------------------
  // sequencer: each bit is four quarter phases
  // ----------------------------------------------------------------
  ms_state_t state;
  ms_state_t next_state;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic [4:0] bitn;
  logic [4:0] next_bitn;
  logic [17:0] frame;
  logic [17:0] next_frame;
  logic rd;
  logic next_rd;
  logic scl_lo;
  logic next_scl_lo;
  logic sda_lo;
  logic next_sda_lo;
  logic nack;
  logic next_nack;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic done;
  logic next_done;
  logic qtick;
  logic sda_s;
  assign qtick = (tick == 16'(QTR - 1));

  line_filter #(.INIT(1'b1)) u_sda_in (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_line(bus.sda),
    .o_level(sda_s)
  );

  always_comb begin
    next_state = state;
    next_tick = qtick ? 16'h0000 : tick + 16'h0001;
    next_ph = ph;
    next_bitn = bitn;
    next_frame = frame;
    next_rd = rd;
    next_scl_lo = scl_lo;
    next_sda_lo = sda_lo;
    next_nack = nack;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      MS_IDLE: begin
        next_tick = 16'h0000;
        next_ph = 2'h0;
        if (i_req) begin
          next_rd = i_read;
          // read frame leaves data and final ack released (ones)
          next_frame = {i_addr, i_read, 1'b1, (i_read ? 8'hFF : i_wdata), 1'b1};
          next_sda_lo = 1'b1;
          next_state = MS_START;
          next_nack = 1'b0;
        end
      end
      MS_START: begin
        if (qtick) begin
          next_scl_lo = 1'b1;
          next_bitn = 5'h00;
          next_state = MS_BITS;
        end
      end
      MS_BITS: begin
        if (qtick) begin
          next_ph = ph + 2'h1;
          case (ph)
            2'h0: next_sda_lo = !frame[17];
            2'h1: next_scl_lo = 1'b0;
            2'h2: begin
              if (bitn == 5'h08 && sda_s) begin
                next_nack = 1'b1;
              end
              if (rd && bitn > 5'h08 && bitn < 5'h11) begin
                next_rdata = {rdata[6:0], sda_s};
              end
            end
            default: begin
              next_scl_lo = 1'b1;
              next_frame = {frame[16:0], 1'b1};
              next_bitn = bitn + 5'h01;
              if (bitn == 5'h11 || (bitn == 5'h08 && nack)) begin
                next_sda_lo = 1'b1;
                next_state = MS_STOP;
                next_ph = 2'h0;
              end
            end
          endcase
        end
      end
      MS_STOP: begin
        if (qtick) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h0) begin
            next_scl_lo = 1'b0;
          end else if (ph == 2'h1) begin
            next_sda_lo = 1'b0;
            next_state = MS_DONE;
          end
        end
      end
      MS_DONE: begin
        next_done = 1'b1;
        next_state = MS_IDLE;
      end
      default: begin
        next_state = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= MS_IDLE;
      tick <= 16'h0000;
      ph <= 2'h0;
      bitn <= 5'h00;
      frame <= 18'h3FFFF;
      rd <= 1'b0;
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      tick <= next_tick;
      ph <= next_ph;
      bitn <= next_bitn;
      frame <= next_frame;
      rd <= next_rd;
      scl_lo <= next_scl_lo;
      sda_lo <= next_sda_lo;
      nack <= next_nack;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

  assign bus.scl_oe_m = scl_lo;
  assign bus.sda_oe_m = sda_lo;
  assign o_ready = (state == MS_IDLE);
  assign o_done = done;
  assign o_nack = nack;
  assign o_rdata = rdata;
endmodule

// ===== test/pot_link_sva.sv
// Purpose: protocol checks on the wires of the wiper link
// Assumes: one master and one device on the watched bus
// Notes: sees only the interface signals, bit count kept in helper logic
`timescale 1ns/1ps
module pot_link_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic scl_oe_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [4:0] rises;
  logic [8:0] shift;
  logic [4:0] next_rises;
  logic [8:0] next_shift;
  logic rise;
  logic start;
  logic stop;
  // ----------------------------------------
  // bit counter since the last start
  // ----------------------------------------
  always_comb begin
    rise = scl && !scl_q;
    start = scl && scl_q && sda_q && !sda;
    stop = scl && scl_q && !sda_q && sda;
    next_rises = rises;
    next_shift = shift;
    if (start) begin
      next_rises = 5'h00;
    end else if (rise) begin
      next_rises = rises + 5'h01;
      next_shift = {shift[7:0], sda};
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      rises <= 5'h00;
      shift <= 9'h000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rises <= next_rises;
      shift <= next_shift;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence clock_pulse;
    ##[1:40] scl ##[1:40] !scl;
  endsequence
  a_scl_master_only: assert property (!scl |-> scl_oe_m && !scl_oe_s)
    else $error("clock held low by device or undriven");
  a_slave_low_change: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("device moved data while clock high");
  a_drive_held_high: assert property ($rose(sda_oe_s) |-> sda_oe_s throughout clock_pulse)
    else $error("device drive not held over the clock pulse");
  a_ack_window: assert property ($rose(sda_oe_s) |-> rises >= 5'h08 && rises <= 5'h11)
    else $error("device drove data outside its slots");
  a_addr_match: assert property (rise && rises == 5'h08 |->
      sda == (shift[7:1] != pot_pkg::DEV_ADDR))
    else $error("address answer wrong");
  a_nack_frees: assert property (rise && rises == 5'h08 && shift[7:1] != pot_pkg::DEV_ADDR
      |=> !sda_oe_s [*8])
    else $error("device drove after foreign address");
  a_read_msb_clear: assert property (rise && rises == 5'h09 &&
      shift[8:1] == {pot_pkg::DEV_ADDR, 1'h1} |-> !sda)
    else $error("read data top bit not zero");
  a_start_quiet: assert property (start |-> sda_oe_m ##1 !sda_oe_s [*8])
    else $error("device drove at start");
  a_stop_quiet: assert property (stop |=> !sda_oe_s [*8])
    else $error("device drove after stop");
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the wiper link, both ends
// Assumes: master quarter bit shortened to 8 system clocks
// Notes: second bus is bit-banged by the bench to break the protocol
`timescale 1ns/1ps
module testbench;
  localparam int LIMIT = 30000;
  logic i_sys_clk;
  logic i_rst;
  logic i_req;
  logic i_read;
  logic [6:0] i_addr;
  logic [7:0] i_wdata;
  logic done;
  logic ready;
  logic nack;
  logic [7:0] rdata;
  logic [6:0] wiper;
  logic busy;
  logic [6:0] wiper2;
  logic busy2;
  logic coll2;
  logic [18:0] bits = 19'h00000;
  logic coll_seen = 1'h0;
  logic [8:0] got;
  logic [6:0] bad_addr [3] = '{7'h2E, pot_pkg::GCALL_ADDR, 7'h6F};
  int cycles = 0;
  int failures = 0;
  int samples_checked = 0;
  pot_if bus();
  pot_if bus2();
  pot_bus_master #(.QTR(8)) pot_bus_master_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_ce(1'h1), .bus(bus), .i_req(i_req), .i_read(i_read), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_ready(ready), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  pot_wiper_dev pot_wiper_dev_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'h1),
    .bus(bus), .o_wiper(wiper), .o_busy(busy), .o_collision());
  pot_wiper_dev pot_wiper_dev_inst_b (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(1'h1),
    .bus(bus2), .o_wiper(wiper2), .o_busy(busy2), .o_collision(coll2));
  pot_link_sva pot_link_sva_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .scl_oe_m(bus.scl_oe_m), .sda_oe_m(bus.sda_oe_m), .scl_oe_s(bus.scl_oe_s),
    .sda_oe_s(bus.sda_oe_s), .scl(bus.scl), .sda(bus.sda));
  initial begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // wire capture: one bit per clock rise, the stop's own rise lands last
  always @(posedge bus.scl) bits <= {bits[17:0], bus.sda};
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (coll2 === 1'h1) coll_seen <= 1'h1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      summarize();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run_op(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    repeat (3) @(posedge i_sys_clk);
    i_req <= 1'h1;
    i_read <= rd;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_req <= 1'h0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (done !== 1'h1 && n < 2000);
    chk(n < 2000, "no done");
    chk(ready === 1'h1, "not ready after done");
  endtask
  // one phase on the second bus; 1 means released
  task automatic step(input logic c, input logic d);
    @(posedge i_sys_clk);
    bus2.scl_oe_m <= !c;
    bus2.sda_oe_m <= !d;
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic xfer(input logic [8:0] v, output logic [8:0] s);
    for (int i = 8; i >= 0; i--) begin
      step(1'h0, v[i]);
      step(1'h1, v[i]);
      s[i] = bus2.sda;
      step(1'h0, v[i]);
    end
  endtask
  // also serves as a repeated start from clock low
  task automatic start2;
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask
  task automatic stop2;
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(negedge i_sys_clk);
    chk(wiper === pot_pkg::WIPER_RESET, "wiper reset value");
    chk(bus.scl === 1'h1 && bus.sda === 1'h1, "lines not idle");
  endtask
  task automatic t_write;
    run_op(1'h0, pot_pkg::DEV_ADDR, 8'hC5);
    chk(wiper === 7'h45 && nack === 1'h0, "write result");
    chk(bits === {pot_pkg::DEV_ADDR, 1'h0, 1'h0, 8'hC5, 1'h0, 1'h0}, "write frame");
    // device sees the stop a few clocks after the master reports done
    repeat (8) @(negedge i_sys_clk);
    chk(busy === 1'h0, "busy after stop");
  endtask
  task automatic t_read;
    run_op(1'h1, pot_pkg::DEV_ADDR, 8'h00);
    chk(rdata === 8'h45, "read data");
    chk(bits === {pot_pkg::DEV_ADDR, 1'h1, 1'h0, 1'h0, 7'h45, 1'h1, 1'h0},
      "read frame");
  endtask
  task automatic t_bad_addr;
    for (int i = 0; i < 3; i++) begin
      run_op(1'h0, bad_addr[i], 8'h11);
      chk(nack === 1'h1 && wiper === 7'h45, "foreign address taken");
      chk(bits[9:0] === {bad_addr[i], 1'h0, 1'h1, 1'h0}, "foreign frame");
    end
    run_op(1'h0, pot_pkg::DEV_ADDR, 8'h80);
    chk(wiper === 7'h00 && nack === 1'h0, "write after refusal");
  endtask
  task automatic t_restart;
    logic s;
    start2();
    xfer({8'h5E, 1'h1}, got);
    chk(got[0] === 1'h0, "address not acknowledged");
    // seven data bits, then an eighth cut by a start before its ack
    for (int i = 0; i < 7; i++) begin
      step(1'h0, 1'h0);
      step(1'h1, 1'h0);
    end
    step(1'h0, 1'h0);
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    s = bus2.sda;
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    chk(wiper2 === pot_pkg::WIPER_RESET && s === 1'h1, "aborted byte stored");
    xfer({8'h5E, 1'h1}, got);
    chk(got[0] === 1'h0, "restart not taken");
    xfer({8'h92, 1'h1}, got);
    stop2();
    chk(got[0] === 1'h0 && wiper2 === 7'h12, "write after restart");
  endtask
  task automatic t_glitch;
    @(posedge i_sys_clk);
    bus2.sda_oe_m <= 1'h1;
    @(posedge i_sys_clk);
    bus2.sda_oe_m <= 1'h0;
    repeat (10) @(posedge i_sys_clk);
    chk(busy2 === 1'h0, "spike seen as start");
  endtask
  task automatic t_collision;
    start2();
    xfer({8'h5F, 1'h1}, got);
    chk(got[0] === 1'h0, "read address refused");
    xfer({8'hFF, 1'h1}, got);
    chk(got[8:1] === 8'h12, "read data on wire");
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    chk(coll_seen === 1'h1, "no collision flagged");
    step(1'h1, 1'h1);
    chk(wiper2 === 7'h12, "wiper altered");
    // second read: clock rises with data high, then falls before data does
    start2();
    xfer({8'h5F, 1'h1}, got);
    xfer({8'hFF, 1'h1}, got);
    coll_seen <= 1'h0;
    step(1'h1, 1'h1);
    chk(coll_seen === 1'h0, "collision on clean restart setup");
    step(1'h0, 1'h1);
    chk(coll_seen === 1'h1, "clock fell before data");
    stop2();
  endtask
  initial begin
    i_rst = 1'h1;
    i_req = 1'h0;
    i_read = 1'h0;
    i_addr = 7'h00;
    i_wdata = 8'h00;
    bus2.scl_oe_m = 1'h0;
    bus2.sda_oe_m = 1'h0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_reset();
    t_write();
    t_read();
    t_bad_addr();
    t_restart();
    t_glitch();
    t_collision();
    summarize();
  end
endmodule
